//--- rtl/wdg_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

// ------------------------------------------------------------
// Clock and time base
// ------------------------------------------------------------
`define WDG_CLK_NS 40
`define WDG_TICK_NS 10000
`define WDG_TICK_CYC (`WDG_TICK_NS / `WDG_CLK_NS)
`define WDG_TICK_US (`WDG_TICK_NS / 1000)
// Rounded up to whole ticks, kept in microseconds to stay within 32 bits
`define WDG_TICKS(us) (((us) + `WDG_TICK_US - 1) / `WDG_TICK_US)

// ------------------------------------------------------------
// Periods in microseconds
// ------------------------------------------------------------
`define WDG_T30US_US 30
`define WDG_T200US_US 200
`define WDG_T300US_US 300
`define WDG_T1MS_US 1000
`define WDG_T3MS_US 3000
`define WDG_T10MS_US 10000
`define WDG_T30MS_US 30000
`define WDG_T100MS_US 100000
`define WDG_T300MS_US 300000
`define WDG_T1S_US 1000000
`define WDG_T3S_US 3000000
`define WDG_T10S_US 10000000
`define WDG_T60S_US 60000000

// ------------------------------------------------------------
// Select codes
// ------------------------------------------------------------
`define WDG_SEL_OFF 3'h3
`define WDG_SEL_FE0 3'h5
`define WDG_SEL_FE1 3'h6
`define WDG_CFG_RST 4'h8

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define WDG_CTRL_OFS 8'h00
`define WDG_STAT_OFS 8'h04
`define WDG_CNT_OFS 8'h08
`define WDG_CTRL_EN_BIT 0
`define WDG_CTRL_RST 1'h1
`define WDG_STAT_STATE_LSB 0
`define WDG_STAT_OUT_BIT 8
`define WDG_STAT_SEL_LSB 16
`define WDG_STAT_EN_BIT 24
`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

`endif

//--- rtl/wdg_pkg.sv
// Types shared by the watchdog and its register slave
package wdg_pkg;

  // Timing table family
  typedef enum logic [1:0] {
    WDG_VAR_A = 2'h0,
    WDG_VAR_B = 2'h1,
    WDG_VAR_C = 2'h2
  } wdg_variant_type;

  // Supervisor states, one-hot
  typedef enum logic [5:0] {
    WDG_ST_SETTLE  = 6'h01,
    WDG_ST_STARTUP = 6'h02,
    WDG_ST_FIRST   = 6'h04,
    WDG_ST_WATCH   = 6'h08,
    WDG_ST_FAULT   = 6'h10,
    WDG_ST_OFF     = 6'h20
  } wdg_state_type;

  // Software control bits
  typedef struct packed {
    logic en;
  } wdg_ctrl_type;

  // Observable state for status reads
  typedef struct packed {
    logic [5:0] state;
    logic fault_n;
    logic [2:0] sel;
    logic en;
    logic [31:0] cnt;
  } wdg_stat_type;

endpackage : wdg_pkg

//--- rtl/wdg_axil_regs.sv
// AXI4-Lite register slave of the watchdog
`timescale 1ns/10ps
`include "wdg_regs.svh"

module wdg_axil_regs #(
  parameter int unsigned AW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output wdg_pkg::wdg_ctrl_type ctrl_o,
  input wire wdg_pkg::wdg_stat_type stat_i
);

  // Write-side holding registers
  logic aw_hold_r;
  logic [AW-1:0] aw_addr_r;
  logic w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // Known register word offset
  function automatic logic wdg_hit_f(input logic [AW-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    return (o == `WDG_CTRL_OFS) || (o == `WDG_STAT_OFS) ||
           (o == `WDG_CNT_OFS);
  endfunction : wdg_hit_f

  // Write channels are free while nothing is held and no response waits; read address while no read data waits
  assign s_axi_awready_o = !aw_hold_r && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_hold_r && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  // ------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------
  // Capture address and data in either order, answer when both held
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `WDG_RESP_OKAY;
      ctrl_o.en <= `WDG_CTRL_RST;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      // Commit the write and raise the response
      if (aw_hold_r && w_hold_r)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wdg_hit_f(aw_addr_r) ? `WDG_RESP_OKAY :
                                                 `WDG_RESP_SLVERR;
        if (8'(aw_addr_r) == `WDG_CTRL_OFS && w_strb_r[0])
          ctrl_o.en <= w_data_r[`WDG_CTRL_EN_BIT];
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Registered read data, zero and error for unmapped words
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= `WDG_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= wdg_hit_f(s_axi_araddr_i) ? `WDG_RESP_OKAY :
                                                    `WDG_RESP_SLVERR;
      s_axi_rdata_o <= 32'h0;
      case (8'(s_axi_araddr_i))
        `WDG_CTRL_OFS: s_axi_rdata_o[`WDG_CTRL_EN_BIT] <= ctrl_o.en;
        `WDG_STAT_OFS:
        begin
          s_axi_rdata_o[`WDG_STAT_STATE_LSB +: 6] <= stat_i.state;
          s_axi_rdata_o[`WDG_STAT_OUT_BIT] <= stat_i.fault_n;
          s_axi_rdata_o[`WDG_STAT_SEL_LSB +: 3] <= stat_i.sel;
          s_axi_rdata_o[`WDG_STAT_EN_BIT] <= stat_i.en;
        end
        `WDG_CNT_OFS: s_axi_rdata_o <= stat_i.cnt;
        default: s_axi_rdata_o <= 32'h0;
      endcase
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

endmodule : wdg_axil_regs

//--- rtl/wdg_watchdog.sv
// Pin-selectable watchdog supervisor with AXI4-Lite status and control
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "wdg_regs.svh"

// Function
// RQ1 - Strobe edge or fault clears countdown
// RQ2 - Steady strobe for timeout gives fault pulse
// RQ3 - Output stays high while strobes arrive
// RQ4 - Code 011 disables countdown and faults
// RQ5 - Variant A: startup equals timeout table
// RQ6 - Variant B: 60s startup, own timeouts
// RQ7 - Variant C startup delay table
// RQ8 - Variant C timeout table
// RQ9 - First-edge modes wait, no deadline
// RQ10 - Startup restarts on power-up, select change
// RQ11 - No countdown or fault during startup
// RQ12 - After startup, timeout counting and monitoring
// RQ13 - Pulse width by output option parameter
// RQ14 - Host strobes before startup delay ends
// RQ15 - Host strobes before each timeout ends
// RQ16 - Strobes ignored during fault and startup
// RQ17 - Settling interval ignores strobes first
// RQ18 - Output high while disabled
// RQ19 - Timeout restarts fully after fault pulse
// RQ20 - Periods counted in prescaled ticks
// RQ21 - Inputs synchronised before edge detection
// RQ22 - Variant chosen by design parameter
module wdg_watchdog #(
  parameter wdg_pkg::wdg_variant_type VARIANT = wdg_pkg::WDG_VAR_A,
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int unsigned TICK_CYC = `WDG_TICK_CYC,
  parameter int unsigned T30US = `WDG_TICKS(`WDG_T30US_US),
  parameter int unsigned T200US = `WDG_TICKS(`WDG_T200US_US),
  parameter int unsigned T300US = `WDG_TICKS(`WDG_T300US_US),
  parameter int unsigned T1MS = `WDG_TICKS(`WDG_T1MS_US),
  parameter int unsigned T3MS = `WDG_TICKS(`WDG_T3MS_US),
  parameter int unsigned T10MS = `WDG_TICKS(`WDG_T10MS_US),
  parameter int unsigned T30MS = `WDG_TICKS(`WDG_T30MS_US),
  parameter int unsigned T100MS = `WDG_TICKS(`WDG_T100MS_US),
  parameter int unsigned T300MS = `WDG_TICKS(`WDG_T300MS_US),
  parameter int unsigned T1S = `WDG_TICKS(`WDG_T1S_US),
  parameter int unsigned T3S = `WDG_TICKS(`WDG_T3S_US),
  parameter int unsigned T10S = `WDG_TICKS(`WDG_T10S_US),
  parameter int unsigned T60S = `WDG_TICKS(`WDG_T60S_US)
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic strobe_in_i,
  input wire logic period_select_0_i,
  input wire logic period_select_1_i,
  input wire logic period_select_2_i,
  output logic fault_pulse_out_n_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  // Fault pulse width by output option
  localparam int unsigned TPULSE = OPEN_DRAIN ?
    `WDG_TICKS(`WDG_T100MS_US) : `WDG_TICKS(`WDG_T1MS_US);

  wdg_pkg::wdg_state_type state_r;   // Supervisor state
  wdg_pkg::wdg_state_type state_nxt; // Next state
  wdg_pkg::wdg_ctrl_type ctrl;       // Software control
  wdg_pkg::wdg_stat_type stat;       // Status to slave
  logic [2:0] strb_sync_r;           // Strobe synchroniser and history
  logic [2:0] sel_meta_r;            // Select first stage
  logic [2:0] sel_s_r;               // Select second stage
  logic [3:0] cfg_act_r;             // Enable and select in force
  logic [3:0] cfg_now;               // Enable and select now
  logic cfg_chg;                     // Configuration differs
  logic [31:0] ps_r;                 // Tick prescaler
  logic tick;                        // One time-base tick
  logic [31:0] cnt_r;                // Period counter in ticks
  logic [31:0] limit;                // Length of current period
  logic done;                        // Current period elapsed
  logic edge_s;                      // Strobe transition seen
  logic cnt_clr;                     // Restart period counter
  logic load_cfg;                    // Adopt new configuration
  logic off_cfg;                     // Configuration is disabled
  logic fe_cfg;                      // Configuration is first-edge

  // ------------------------------------------------------------
  // Timing tables
  // ------------------------------------------------------------
  // Timeout ticks for a select code
  function automatic logic [31:0] wdg_tmo_f(input logic [2:0] s);
    logic [31:0] t;
    t = 32'(T1MS);
    case (VARIANT) // RQ22
      wdg_pkg::WDG_VAR_C: // RQ8
        case (s)
          3'h0: t = 32'(T3MS);
          3'h1: t = 32'(T3S);
          3'h2: t = 32'(T1S);
          3'h4: t = 32'(T30US);
          3'h5: t = 32'(T1S);
          default: t = 32'(T10S);
        endcase
      wdg_pkg::WDG_VAR_B: // RQ6
        case (s)
          3'h0: t = 32'(T1MS);
          3'h1: t = 32'(T3MS);
          3'h2: t = 32'(T10MS);
          3'h4: t = 32'(T100MS);
          3'h5: t = 32'(T300MS);
          3'h6: t = 32'(T3S);
          default: t = 32'(T60S);
        endcase
      default: // RQ5
        case (s)
          3'h0: t = 32'(T1MS);
          3'h1: t = 32'(T10MS);
          3'h2: t = 32'(T30MS);
          3'h4: t = 32'(T100MS);
          3'h5: t = 32'(T1S);
          3'h6: t = 32'(T10S);
          default: t = 32'(T60S);
        endcase
    endcase
    return t;
  endfunction : wdg_tmo_f

  // Startup delay ticks for a select code
  function automatic logic [31:0] wdg_start_f(input logic [2:0] s);
    logic [31:0] t;
    t = wdg_tmo_f(s); // RQ5
    if (VARIANT == wdg_pkg::WDG_VAR_B)
      t = 32'(T60S); // RQ6
    else if (VARIANT == wdg_pkg::WDG_VAR_C)
      case (s) // RQ7
        3'h0: t = 32'(T3MS);
        3'h1: t = 32'(T3S);
        3'h4: t = 32'(T200US);
        default: t = 32'(T60S);
      endcase
    return t;
  endfunction : wdg_start_f

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Two stages, then a history stage for edge detection
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strb_sync_r <= 3'h0;
      sel_meta_r <= 3'h0;
      sel_s_r <= 3'h0;
    end
    else
    begin
      strb_sync_r <= {strb_sync_r[1:0], strobe_in_i}; // RQ21
      sel_meta_r <= {period_select_2_i, period_select_1_i,
                     period_select_0_i}; // RQ21
      sel_s_r <= sel_meta_r;
    end
  end

  // Edge seen between second and third stage
  assign edge_s = strb_sync_r[2] ^ strb_sync_r[1]; // RQ1
  assign cfg_now = {ctrl.en, sel_s_r};
  assign cfg_chg = cfg_now != cfg_act_r; // RQ10
  assign off_cfg = !cfg_act_r[3] || cfg_act_r[2:0] == `WDG_SEL_OFF;
  assign fe_cfg = VARIANT == wdg_pkg::WDG_VAR_C &&
                  (cfg_act_r[2:0] == `WDG_SEL_FE0 ||
                   cfg_act_r[2:0] == `WDG_SEL_FE1);

  // ------------------------------------------------------------
  // Time base and period counter
  // ------------------------------------------------------------
  // Prescaler restarts with the counter so periods stay whole
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ps_r <= 32'h0;
    else if (cnt_clr || tick)
      ps_r <= 32'h0;
    else
      ps_r <= ps_r + 32'h1;
  end

  assign tick = ps_r == 32'(TICK_CYC - 1); // RQ20

  // Period length for the present state
  always_comb
  begin
    case (state_r)
      wdg_pkg::WDG_ST_SETTLE: limit = 32'(T300US); // RQ17
      wdg_pkg::WDG_ST_STARTUP: limit = wdg_start_f(cfg_act_r[2:0]);
      wdg_pkg::WDG_ST_WATCH: limit = wdg_tmo_f(cfg_act_r[2:0]);
      wdg_pkg::WDG_ST_FAULT: limit = 32'(TPULSE); // RQ13
      default: limit = 32'hFFFFFFFF;
    endcase
  end

  assign done = tick && (cnt_r >= limit - 32'h1); // RQ20

  // Count ticks, clear on restart
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_r <= 32'h0;
    else if (cnt_clr)
      cnt_r <= 32'h0; // RQ1
    else if (tick)
      cnt_r <= cnt_r + 32'h1;
  end

  // ------------------------------------------------------------
  // Supervisor state machine
  // ------------------------------------------------------------
  // Next state, counter restart and configuration load
  always_comb
  begin
    state_nxt = state_r;
    cnt_clr = 1'b0;
    load_cfg = 1'b0;
    case (state_r)
      wdg_pkg::WDG_ST_FAULT:
        // Pulse always finishes under the old setting
        if (done)
        begin
          cnt_clr = 1'b1; // RQ19
          if (cfg_chg)
          begin
            state_nxt = wdg_pkg::WDG_ST_SETTLE;
            load_cfg = 1'b1;
          end
          else
            state_nxt = wdg_pkg::WDG_ST_WATCH; // RQ19
        end
      wdg_pkg::WDG_ST_SETTLE,
      wdg_pkg::WDG_ST_STARTUP,
      wdg_pkg::WDG_ST_FIRST,
      wdg_pkg::WDG_ST_WATCH,
      wdg_pkg::WDG_ST_OFF:
        if (cfg_chg)
        begin
          // Any select change restarts settling
          state_nxt = wdg_pkg::WDG_ST_SETTLE; // RQ10
          cnt_clr = 1'b1;
          load_cfg = 1'b1;
        end
        else if (state_r == wdg_pkg::WDG_ST_SETTLE && done)
        begin
          cnt_clr = 1'b1;
          if (off_cfg)
            state_nxt = wdg_pkg::WDG_ST_OFF; // RQ4
          else if (fe_cfg)
            state_nxt = wdg_pkg::WDG_ST_FIRST; // RQ9
          else
            state_nxt = wdg_pkg::WDG_ST_STARTUP; // RQ11
        end
        else if (state_r == wdg_pkg::WDG_ST_STARTUP && done)
        begin
          state_nxt = wdg_pkg::WDG_ST_WATCH; // RQ12
          cnt_clr = 1'b1;
        end
        else if (state_r == wdg_pkg::WDG_ST_FIRST && edge_s)
        begin
          state_nxt = wdg_pkg::WDG_ST_WATCH; // RQ9
          cnt_clr = 1'b1;
        end
        else if (state_r == wdg_pkg::WDG_ST_WATCH && edge_s) // RQ16
          cnt_clr = 1'b1; // RQ1 RQ3
        else if (state_r == wdg_pkg::WDG_ST_WATCH && done)
        begin
          state_nxt = wdg_pkg::WDG_ST_FAULT; // RQ2
          cnt_clr = 1'b1; // RQ1
        end
        else
          state_nxt = state_r;
      default:
      begin
        state_nxt = wdg_pkg::WDG_ST_SETTLE;
        cnt_clr = 1'b1;
      end
    endcase
  end

  // State register, power-up enters settling
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= wdg_pkg::WDG_ST_SETTLE; // RQ10
    else
      state_r <= state_nxt;
  end

  // Configuration in force, adopted at each settling start
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_act_r <= `WDG_CFG_RST;
    else if (load_cfg)
      cfg_act_r <= cfg_now;
  end

  // Fault output from a flop, low only in the fault state
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fault_pulse_out_n_o <= 1'b1;
    else
      fault_pulse_out_n_o <= state_nxt != wdg_pkg::WDG_ST_FAULT; // RQ2 RQ18
  end

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  assign stat.state = state_r;
  assign stat.fault_n = fault_pulse_out_n_o;
  assign stat.sel = cfg_act_r[2:0];
  assign stat.en = cfg_act_r[3];
  assign stat.cnt = cnt_r;

  // Software enable in, state and counter out
  wdg_axil_regs #(.AW(8)) u_regs (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .ctrl_o(ctrl),
    .stat_i(stat)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb_wdg @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Timeout reached while watching
  sequence s_timeout_hit;
    state_r == wdg_pkg::WDG_ST_WATCH && !cfg_chg && !edge_s && done;
  endsequence

  // Fault state entered with the output low
  sequence s_fault_on;
    state_r == wdg_pkg::WDG_ST_FAULT && !fault_pulse_out_n_o;
  endsequence

  property p_timeout_fault;
    s_timeout_hit |=> s_fault_on;
  endproperty
  a_timeout_fault: assert property (p_timeout_fault) // RQ2
    else $error("Timeout did not raise a fault pulse");

  property p_edge_clears;
    state_r == wdg_pkg::WDG_ST_WATCH && edge_s && !cfg_chg
      |=> cnt_r == 32'h0 && fault_pulse_out_n_o;
  endproperty
  a_edge_clears: assert property (p_edge_clears) // RQ1
    else $error("Strobe edge did not clear the countdown");

  property p_fault_cnt_zero;
    $fell(fault_pulse_out_n_o) |-> cnt_r == 32'h0;
  endproperty
  a_fault_cnt_zero: assert property (p_fault_cnt_zero) // RQ1
    else $error("Countdown not cleared at fault assertion");

  property p_off_high;
    state_r == wdg_pkg::WDG_ST_OFF |-> fault_pulse_out_n_o;
  endproperty
  a_off_high: assert property (p_off_high) // RQ18
    else $error("Output low while disabled");

  property p_startup_quiet;
    (state_r == wdg_pkg::WDG_ST_STARTUP ||
     state_r == wdg_pkg::WDG_ST_SETTLE) |-> fault_pulse_out_n_o;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet) // RQ11
    else $error("Fault during startup or settling");

  property p_sel_restart;
    state_r != wdg_pkg::WDG_ST_FAULT && cfg_chg
      |=> state_r == wdg_pkg::WDG_ST_SETTLE && cnt_r == 32'h0;
  endproperty
  a_sel_restart: assert property (p_sel_restart) // RQ10
    else $error("Select change did not restart settling");

  property p_pulse_held;
    !fault_pulse_out_n_o && !done |=> !fault_pulse_out_n_o;
  endproperty
  a_pulse_held: assert property (p_pulse_held) // RQ13
    else $error("Fault pulse ended early");

  property p_pulse_end;
    state_r == wdg_pkg::WDG_ST_FAULT && done
      |=> fault_pulse_out_n_o && cnt_r == 32'h0;
  endproperty
  a_pulse_end: assert property (p_pulse_end) // RQ19
    else $error("Countdown not restarted after fault pulse");

  property p_first_waits;
    state_r == wdg_pkg::WDG_ST_FIRST && !edge_s && !cfg_chg
      |=> state_r == wdg_pkg::WDG_ST_FIRST && fault_pulse_out_n_o;
  endproperty
  a_first_waits: assert property (p_first_waits) // RQ9
    else $error("First-edge wait left without a strobe edge");

  property p_settle_ignores;
    state_r == wdg_pkg::WDG_ST_SETTLE && !done && !cfg_chg
      |=> state_r == wdg_pkg::WDG_ST_SETTLE;
  endproperty
  a_settle_ignores: assert property (p_settle_ignores) // RQ17
    else $error("Settling ended before its interval");

endmodule : wdg_watchdog

//--- verification/wdg_host_model.sv
// Host model that toggles the strobe while it runs
`timescale 1ns/10ps
module wdg_host_model #(
  parameter int unsigned GAP = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic strobe_o
);
  logic [7:0] gap_r; // Cycles since last toggle
  // Toggle well inside every period while running
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gap_r <= 8'h00;
      strobe_o <= 1'h0;
    end
    else if (run_i && gap_r == GAP[7:0] - 8'h01)
    begin
      gap_r <= 8'h00;
      strobe_o <= ~strobe_o;
    end
    else
      gap_r <= gap_r + 8'h01;
  end
endmodule : wdg_host_model

//--- verification/wdg_watchdog_tb_top.sv
// Bench for the watchdog pins and its register bus
`timescale 1ns/10ps
module wdg_watchdog_tb_top;
  logic mclk = 1'h0, rst_n = 1'h0, run = 1'h0, strobe, fault_n;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, a_ok, w_ok;
  logic [2:0] sel = 3'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  int errors = 0, n_tests = 0, n;
  initial forever #20 mclk = ~mclk;
  wdg_host_model #(.GAP(4)) i_wdg_host_model (.mclk_i(mclk),
    .rst_n_i(rst_n), .run_i(run), .strobe_o(strobe));
  wdg_watchdog #(.OPEN_DRAIN(1'h0), .TICK_CYC(2), .T300US(5), .T1MS(4))
  i_wdg_watchdog (.mclk_i(mclk), .rst_n_i(rst_n), .strobe_in_i(strobe),
    .period_select_0_i(sel[0]), .period_select_1_i(sel[1]),
    .period_select_2_i(sel[2]), .fault_pulse_out_n_o(fault_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Count edges while the fault pin holds a level
  task automatic meas(input logic lvl, input int lim);
    n = 0;
    while (fault_n === lvl && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask : meas
  // Register write, both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    a_ok = 1'h0;
    w_ok = 1'h0;
    while (!(a_ok && w_ok))
    begin
      @(posedge mclk);
      a_ok = a_ok | awready;
      w_ok = w_ok | wready;
      awv <= ~a_ok;
      wv <= ~w_ok;
    end
    do @(posedge mclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, 2'h0);
    @(posedge mclk);
  endtask : axw
  // Register read with expected data and response
  task automatic axr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do @(posedge mclk); while (arready !== 1'h1);
    arv <= 1'h0;
    do @(posedge mclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, d);
    chk(rresp, r);
    @(posedge mclk);
  endtask : axr
  // Silent host after reset: one fault pulse, then a fresh timeout
  task automatic t_timeout;
    meas(1'h1, 1000);
    chk(n >= 24 && n <= 36, 1);
    meas(1'h0, 1000);
    chk(n >= 199 && n <= 210, 1);
    meas(1'h1, 1000);
    chk(n >= 7 && n <= 12, 1);
  endtask : t_timeout
  // Host toggling keeps the output high
  task automatic t_strobe;
    run <= 1'h1;
    meas(1'h0, 1000);
    meas(1'h1, 600);
    chk(n, 600);
  endtask : t_strobe
  // Disable code, status and bus checks
  task automatic t_off;
    sel <= 3'h3;
    run <= 1'h0;
    meas(1'h1, 400);
    chk(n, 400);
    axr(8'h04, 32'h0103_0120, 2'h0);
    axr(8'h0C, 32'h0, 2'h2);
    wstrb <= 4'h0;
    axw(8'h00, 32'h0);
    axr(8'h00, 32'h1, 2'h0);
    wstrb <= 4'hF;
    axw(8'h00, 32'h0);
    axr(8'h00, 32'h0, 2'h0);
    axw(8'h00, 32'h1);
  endtask : t_off
  // Leaving the disable code starts a new startup
  task automatic t_restart;
    sel <= 3'h0;
    meas(1'h1, 1000);
    chk(n >= 24 && n <= 40, 1);
  endtask : t_restart
  // Verdict and end of run
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    t_timeout;
    t_strobe;
    t_off;
    t_restart;
    give_verdict;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    give_verdict;
  end
endmodule : wdg_watchdog_tb_top
